// file: dcm_addr_match.sv
// One comparator's address match against the monitored address bus.
`timescale 1ns/1ns
`default_nettype none
module dcm_addr_match #(
    parameter int AW = 18
) (
    input wire logic [AW-1:0] pattern,
    input wire logic [AW-1:0] bus_addr,
    output logic hit
);
    // All monitored bits must equal their pattern bits in the same cycle.
    assign hit = (pattern == bus_addr);
endmodule : dcm_addr_match
`default_nettype wire

// file: dcm_comparators.sv
// Debug comparator address and data match registers with their match logic.
`timescale 1ns/1ns
`default_nettype none
module dcm_comparators #(
    parameter int NC = dcm_pkg::NUM_COMP
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [dcm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dcm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dcm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic debug_armed,
    input wire logic [dcm_pkg::BUS_ADDR_W-1:0] bus_addr,
    input wire logic [dcm_pkg::BUS_DATA_W-1:0] bus_data,
    output logic [NC-1:0] addr_match,
    output logic comp_a_match
);
    localparam int AW = dcm_pkg::BUS_ADDR_W;
    localparam int DW = dcm_pkg::BUS_DATA_W;

    logic [1:0] hi_r [NC];
    logic [7:0] mid_r [NC];
    logic [7:0] low_r [NC];
    logic [7:0] dhi_r;
    logic [7:0] dlo_r;
    logic [7:0] mhi_r;
    logic [7:0] mlo_r;
    logic [1:0] view_r;
    logic tag_r;
    logic armed_s1_r;
    logic armed_r;
    logic [7:0] rdata_nxt;
    logic [NC-1:0] hit;
    logic data_ok;
    logic wr_ok;
    logic [AW-1:0] pattern_w [NC];
    logic [DW-1:0] data_pattern;
    logic [DW-1:0] data_mask;
    logic [DW-1:0] data_diff;

    // Decodes which comparator the view selector exposes; 11 exposes none.
    function automatic logic view_hits(input logic [1:0] view, input int idx);
        view_hits = (view != dcm_pkg::VIEW_NONE) && (int'(view) == idx);
    endfunction : view_hits

    // The arm level comes from the sequencer outside, so it is synchronised first.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_s1_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            armed_s1_r <= debug_armed;
            armed_r <= armed_s1_r;
        end
    end

    // The arm level reaches the write gate on the second edge after it rises outside.
    a_arm_latency: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(debug_armed) |=> ##1 armed_r)
        else $error("arm level not through the synchroniser in time");

    // Pattern writes are dropped silently while the module is armed.
    assign wr_ok = reg_wr && !armed_r;

    // Steps of an accepted write: the strobe, and no arm level seen at the gate.
    sequence s_write_open;
        reg_wr && !armed_r;
    endsequence

    // The accepted write is then steered by its offset.
    sequence s_high_write;
        s_write_open ##0 (reg_addr == dcm_pkg::OFS_ADDR_HIGH);
    endsequence

    sequence s_mid_write;
        s_write_open ##0 (reg_addr == dcm_pkg::OFS_ADDR_MID);
    endsequence

    sequence s_low_write;
        s_write_open ##0 (reg_addr == dcm_pkg::OFS_ADDR_LOW);
    endsequence

    // Data and mask writes also need view 00 selected.
    sequence s_data_write;
        s_write_open ##0 (view_r == dcm_pkg::VIEW_A);
    endsequence

    // View selector and tag select live in a local control register, never blocked.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            view_r <= dcm_pkg::RST_CONTROL[1:0];
            tag_r <= 1'b0;
        end else if (reg_wr && reg_addr == dcm_pkg::OFS_CONTROL) begin
            view_r <= reg_wdata[dcm_pkg::CTRL_VIEW_LSB +: 2];
            tag_r <= reg_wdata[dcm_pkg::CTRL_TAG_BIT];
        end
    end

    // One bank of address pattern registers per comparator.
    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_comp
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    hi_r[gi] <= dcm_pkg::RST_ADDR_HIGH[1:0];
                    mid_r[gi] <= dcm_pkg::RST_ADDR_MID;
                    low_r[gi] <= dcm_pkg::RST_ADDR_LOW;
                end else if (wr_ok && view_hits(view_r, gi)) begin
                    if (reg_addr == dcm_pkg::OFS_ADDR_HIGH) begin
                        hi_r[gi] <= reg_wdata[1:0];
                    end
                    if (reg_addr == dcm_pkg::OFS_ADDR_MID) begin
                        mid_r[gi] <= reg_wdata;
                    end
                    if (reg_addr == dcm_pkg::OFS_ADDR_LOW) begin
                        low_r[gi] <= reg_wdata;
                    end
                end
            end

            // The full pattern word feeds the match cell.
            assign pattern_w[gi] = {hi_r[gi], mid_r[gi], low_r[gi]};

            dcm_addr_match #(
                .AW(AW)
            ) u_match (
                .pattern(pattern_w[gi]),
                .bus_addr(bus_addr),
                .hit(hit[gi])
            );

            // An open high write under this view lands, two bits wide.
            a_high_lands: assert property (@(posedge clk) disable iff (!arst_n)
                (s_high_write ##0 view_hits(view_r, gi))
                |=> (hi_r[gi] == $past(reg_wdata[1:0])))
                else $error("high pattern write lost");

            // An open mid write under this view lands whole.
            a_mid_lands: assert property (@(posedge clk) disable iff (!arst_n)
                (s_mid_write ##0 view_hits(view_r, gi))
                |=> (mid_r[gi] == $past(reg_wdata)))
                else $error("mid pattern write lost");

            // An open low write under this view lands whole.
            a_low_lands: assert property (@(posedge clk) disable iff (!arst_n)
                (s_low_write ##0 view_hits(view_r, gi))
                |=> (low_r[gi] == $past(reg_wdata)))
                else $error("low pattern write lost");

            // A write under another view, or while armed, leaves this bank alone.
            a_bank_kept: assert property (@(posedge clk) disable iff (!arst_n)
                (reg_wr && (armed_r || !view_hits(view_r, gi)))
                |=> ($stable(hi_r[gi]) && $stable(mid_r[gi]) && $stable(low_r[gi])))
                else $error("bank changed by a write it did not own");
        end
    endgenerate

    // Data pattern and mask exist for comparator A only and need view 00.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dhi_r <= dcm_pkg::RST_DATA;
            dlo_r <= dcm_pkg::RST_DATA;
            mhi_r <= dcm_pkg::RST_MASK;
            mlo_r <= dcm_pkg::RST_MASK;
        end else if (wr_ok && view_r == dcm_pkg::VIEW_A) begin
            if (reg_addr == dcm_pkg::OFS_DATA_HIGH) begin
                dhi_r <= reg_wdata;
            end
            if (reg_addr == dcm_pkg::OFS_DATA_LOW) begin
                dlo_r <= reg_wdata;
            end
            if (reg_addr == dcm_pkg::OFS_MASK_HIGH) begin
                mhi_r <= reg_wdata;
            end
            if (reg_addr == dcm_pkg::OFS_MASK_LOW) begin
                mlo_r <= reg_wdata;
            end
        end
    end

    // An open write under view 00 loads the data pattern bytes.
    a_data_high_lands: assert property (@(posedge clk) disable iff (!arst_n)
        (s_data_write ##0 (reg_addr == dcm_pkg::OFS_DATA_HIGH))
        |=> (dhi_r == $past(reg_wdata)))
        else $error("data high write lost");
    a_data_low_lands: assert property (@(posedge clk) disable iff (!arst_n)
        (s_data_write ##0 (reg_addr == dcm_pkg::OFS_DATA_LOW))
        |=> (dlo_r == $past(reg_wdata)))
        else $error("data low write lost");

    // The mask bytes load the same way.
    a_mask_high_lands: assert property (@(posedge clk) disable iff (!arst_n)
        (s_data_write ##0 (reg_addr == dcm_pkg::OFS_MASK_HIGH))
        |=> (mhi_r == $past(reg_wdata)))
        else $error("mask high write lost");
    a_mask_low_lands: assert property (@(posedge clk) disable iff (!arst_n)
        (s_data_write ##0 (reg_addr == dcm_pkg::OFS_MASK_LOW))
        |=> (mlo_r == $past(reg_wdata)))
        else $error("mask low write lost");

    // Off view 00, or while armed, no write reaches the data pattern or mask.
    a_data_locked: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_wr && (armed_r || view_r != dcm_pkg::VIEW_A))
        |=> ($stable(data_pattern) && $stable(data_mask)))
        else $error("data pattern changed by a refused write");

    // Pattern and mask are joined into bus-wide words for the compare.
    assign data_pattern = {dhi_r, dlo_r};
    assign data_mask = {mhi_r, mlo_r};

    // A bit differs only where the mask asks for it; a zero mask bit lets any value pass.
    assign data_diff = (data_pattern ^ bus_data) & data_mask;
    assign data_ok = tag_r || (data_diff == '0);

    // Only A is qualified by data; B and C report address hits alone.
    assign addr_match = hit;
    assign comp_a_match = hit[0] && data_ok;

    // A needs its own address hit whatever the data say.
    a_a_needs_address: assert property (@(posedge clk) disable iff (!arst_n)
        comp_a_match |-> hit[0])
        else $error("comparator A matched off its address");

    // A full address hit with no differing compared bit must match.
    a_a_match_full: assert property (@(posedge clk) disable iff (!arst_n)
        (hit[0] && data_diff == 16'h0000) |-> comp_a_match)
        else $error("comparator A missed a full match");

    // Read mux: address registers under views 00 to 10, data registers only under view 00.
    always_comb begin
        rdata_nxt = '0;
        for (int i = 0; i < NC; i++) begin
            if (view_hits(view_r, i)) begin
                if (reg_addr == dcm_pkg::OFS_ADDR_HIGH) begin
                    rdata_nxt = {6'h00, hi_r[i]};
                end else if (reg_addr == dcm_pkg::OFS_ADDR_MID) begin
                    rdata_nxt = mid_r[i];
                end else if (reg_addr == dcm_pkg::OFS_ADDR_LOW) begin
                    rdata_nxt = low_r[i];
                end
            end
        end
        if (view_r == dcm_pkg::VIEW_A) begin
            if (reg_addr == dcm_pkg::OFS_DATA_HIGH) begin
                rdata_nxt = dhi_r;
            end else if (reg_addr == dcm_pkg::OFS_DATA_LOW) begin
                rdata_nxt = dlo_r;
            end else if (reg_addr == dcm_pkg::OFS_MASK_HIGH) begin
                rdata_nxt = mhi_r;
            end else if (reg_addr == dcm_pkg::OFS_MASK_LOW) begin
                rdata_nxt = mlo_r;
            end
        end
        if (reg_addr == dcm_pkg::OFS_CONTROL) begin
            rdata_nxt = {5'h00, tag_r, view_r};
        end
    end

    // Read data is registered and stands only in the cycle after the strobe.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= '0;
        end
    end

    // Address registers read back under any arm state.
    a_mid_readable: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == dcm_pkg::OFS_ADDR_MID && view_r == dcm_pkg::VIEW_B)
        |=> (reg_rdata == $past(mid_r[1])))
        else $error("mid register not readable");

    // View 11 shows no address register.
    a_view_none_read: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == dcm_pkg::OFS_ADDR_LOW && view_r == dcm_pkg::VIEW_NONE)
        |=> (reg_rdata == 8'h00))
        else $error("address register visible under view none");

    // Under view 00 the data registers read back what was stored.
    a_data_visible: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == dcm_pkg::OFS_DATA_LOW && view_r == dcm_pkg::VIEW_A)
        |=> (reg_rdata == $past(dlo_r)))
        else $error("data low register not readable under view 00");

    // The local control register reads back the view and the tag select.
    a_control_read: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == dcm_pkg::OFS_CONTROL)
        |=> (reg_rdata == {5'h00, $past(tag_r), $past(view_r)}))
        else $error("control register readback wrong");

    // Read data stand only in the cycle after a strobe; software sees zero otherwise.
    a_read_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !reg_rd |=> (reg_rdata == 8'h00))
        else $error("read data standing without a strobe");

    // A write while armed leaves the address pattern untouched.
    a_armed_write_blocked: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_wr && armed_r && reg_addr == dcm_pkg::OFS_ADDR_MID && view_r == dcm_pkg::VIEW_A)
        |=> $stable(mid_r[0])) else $error("address write taken while armed");

    // An unarmed write under view A lands in comparator A.
    a_view_a_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_ok && reg_addr == dcm_pkg::OFS_ADDR_LOW && view_r == dcm_pkg::VIEW_A)
        |=> (low_r[0] == $past(reg_wdata))) else $error("view A write lost");

    // View 11 exposes nothing, so the low bytes of banks B and C do not change.
    a_view_none_idle: assert property (@(posedge clk) disable iff (!arst_n)
        (view_r == dcm_pkg::VIEW_NONE) |=> $stable(low_r[1]) && $stable(low_r[2]))
        else $error("bank changed under view none");

    // High register readback keeps bits 7:2 at zero.
    a_high_upper_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == dcm_pkg::OFS_ADDR_HIGH) |=> (reg_rdata[7:2] == 6'h00))
        else $error("high register upper bits not zero");

    // Data registers read zero when the view is not A.
    a_data_hidden: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == dcm_pkg::OFS_DATA_HIGH && view_r != dcm_pkg::VIEW_A)
        |=> (reg_rdata == 8'h00)) else $error("data register visible off view A");

    // With all masks clear, A matches whenever its address does.
    a_mask_clear: assert property (@(posedge clk) disable iff (!arst_n)
        ({mhi_r, mlo_r} == 16'h0000 && hit[0]) |-> comp_a_match)
        else $error("masked data blocked match");

    // A compared data bit that differs kills A's match unless tagging.
    a_data_mismatch: assert property (@(posedge clk) disable iff (!arst_n)
        (!tag_r && (((bus_data ^ {dhi_r, dlo_r}) & {mhi_r, mlo_r}) != 16'h0000)) |-> !comp_a_match)
        else $error("data mismatch still matched");

    // Tagging ignores data patterns altogether.
    a_tag_ignores: assert property (@(posedge clk) disable iff (!arst_n)
        (tag_r && hit[0]) |-> comp_a_match) else $error("tag mode used data");

    // Address match means every bit equals its pattern.
    a_addr_exact: assert property (@(posedge clk) disable iff (!arst_n)
        addr_match[1] |-> (bus_addr == {hi_r[1], mid_r[1], low_r[1]}))
        else $error("address match without equality");
endmodule : dcm_comparators
`default_nettype wire

// file: dcm_cpu_bus.sv
// Behavioural processor bus that the comparators watch.
`timescale 1ns/1ns
`default_nettype none
module dcm_cpu_bus #(
    parameter int AW = 18,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic aim,
    input wire logic [AW-1:0] aim_addr,
    input wire logic [DW-1:0] aim_data,
    output logic [AW-1:0] bus_addr,
    output logic [DW-1:0] bus_data
);
    // The bus never holds a stale value: a cycle that is not aimed carries fresh noise.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_addr <= '0;
            bus_data <= '0;
        end else if (aim) begin
            bus_addr <= aim_addr;
            bus_data <= aim_data;
        end else begin
            bus_addr <= AW'($urandom);
            bus_data <= DW'($urandom);
        end
    end
endmodule : dcm_cpu_bus
`default_nettype wire

// file: dcm_pkg.sv
// Package of offsets, field layouts and reset values for the debug comparator match registers.
`default_nettype none
package dcm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int BUS_ADDR_W = 18;
    localparam int BUS_DATA_W = 16;
    localparam int NUM_COMP = 3;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h29;
    localparam logic [7:0] OFS_ADDR_MID = 8'h2a;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h2b;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h2c;
    localparam logic [7:0] OFS_DATA_LOW = 8'h2d;
    localparam logic [7:0] OFS_MASK_HIGH = 8'h2e;
    localparam logic [7:0] OFS_MASK_LOW = 8'h2f;
    localparam logic [7:0] OFS_CONTROL = 8'h30;
    localparam int HIGH_BITS = 2;
    localparam logic [1:0] VIEW_A = 2'h0;
    localparam logic [1:0] VIEW_B = 2'h1;
    localparam logic [1:0] VIEW_C = 2'h2;
    localparam logic [1:0] VIEW_NONE = 2'h3;
    localparam int CTRL_VIEW_LSB = 0;
    localparam int CTRL_TAG_BIT = 2;
    localparam logic [7:0] RST_ADDR_HIGH = 8'h00;
    localparam logic [7:0] RST_ADDR_MID = 8'h00;
    localparam logic [7:0] RST_ADDR_LOW = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
endpackage : dcm_pkg
`default_nettype wire

// file: testbench.sv
// Self-checking bench with a reference model of the comparator registers and matches.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, debug_armed = 0, aim = 0, comp_a_match;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [17:0] bus_addr, aim_addr = 0;
    logic [15:0] bus_data, aim_data = 0;
    logic [2:0] addr_match;
    int miscompares = 0, check_count = 0;
    // Reference state, updated only where a write is accepted.
    logic [17:0] pat [3] = '{default: 18'h0};
    logic [15:0] dat = 0, msk = 0;
    logic [1:0] view = 0;
    logic tag = 0, m_arm = 0, live = 0;
    always #50 clk = ~clk;
    dcm_comparators dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .debug_armed(debug_armed), .bus_addr(bus_addr), .bus_data(bus_data),
        .addr_match(addr_match), .comp_a_match(comp_a_match));
    dcm_cpu_bus bus_u (.clk(clk), .arst_n(arst_n), .aim(aim), .aim_addr(aim_addr),
        .aim_data(aim_data), .bus_addr(bus_addr), .bus_data(bus_data));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic void mwr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h30) begin
            view = d[1:0];
            tag = d[2];
        end else if (!m_arm && view != 2'h3) begin
            case (a)
                8'h29: pat[view][17:16] = d[1:0];
                8'h2a: pat[view][15:8] = d;
                8'h2b: pat[view][7:0] = d;
                8'h2c: if (view == 2'h0) dat[15:8] = d;
                8'h2d: if (view == 2'h0) dat[7:0] = d;
                8'h2e: if (view == 2'h0) msk[15:8] = d;
                8'h2f: if (view == 2'h0) msk[7:0] = d;
                default: ;
            endcase
        end
    endfunction : mwr
    function automatic logic [7:0] er(input logic [7:0] a);
        logic [17:0] p;
        logic a_vis;
        p = (view == 2'h3) ? 18'h0 : pat[view];
        a_vis = (view == 2'h0);
        case (a)
            8'h29: return {6'h0, p[17:16]};
            8'h2a: return p[15:8];
            8'h2b: return p[7:0];
            8'h2c: return a_vis ? dat[15:8] : 8'h0;
            8'h2d: return a_vis ? dat[7:0] : 8'h0;
            8'h2e: return a_vis ? msk[15:8] : 8'h0;
            8'h2f: return a_vis ? msk[7:0] : 8'h0;
            8'h30: return {5'h0, tag, view};
            default: return 8'h0;
        endcase
    endfunction : er
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        mwr(a, d);
    endtask : wr
    // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle.
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, er(a));
    endtask : rd
    // Arming passes two flops inside, so the model follows only once that has settled.
    task automatic arm_set(input logic v);
        @(posedge clk);
        debug_armed <= v;
        repeat (3) @(posedge clk);
        m_arm = v;
    endtask : arm_set
    // Match outputs are watched every cycle against the model.
    always @(negedge clk) begin
        if (live) begin
            chk(addr_match, {bus_addr == pat[2], bus_addr == pat[1], bus_addr == pat[0]});
            chk(comp_a_match, bus_addr == pat[0] && (tag || ((bus_data ^ dat) & msk) == 0));
        end
    end
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hee755bdd));
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        live = 1;
        for (int a = 8'h28; a <= 8'h31; a++) rd(8'(a));
        // Every view is written and read back, then the block is armed and written again.
        for (int ph = 0; ph < 2; ph++) begin
            if (ph == 1) arm_set(1'b1);
            for (int v = 0; v < 4; v++) begin
                wr(8'h30, 8'(v));
                for (int a = 8'h29; a <= 8'h2f; a++) wr(8'(a), 8'($urandom));
            end
            for (int v = 0; v < 4; v++) begin
                wr(8'h30, 8'(v));
                for (int a = 8'h28; a <= 8'h31; a++) rd(8'(a));
            end
        end
        arm_set(1'b0);
        // Random patterns with full, empty and partial masks, tagging on and off.
        for (int r = 0; r < 8; r++) begin
            for (int v = 0; v < 3; v++) begin
                wr(8'h30, 8'(v));
                for (int a = 8'h29; a <= 8'h2b; a++) wr(8'(a), 8'($urandom));
            end
            wr(8'h30, {5'h0, r[0], 2'h0});
            wr(8'h2c, 8'($urandom));
            wr(8'h2d, 8'($urandom));
            wr(8'h2e, r < 2 ? 8'h00 : r < 4 ? 8'hff : 8'($urandom));
            wr(8'h2f, r < 2 ? 8'h00 : r < 4 ? 8'hff : 8'($urandom));
            repeat (40) begin
                @(posedge clk);
                aim <= ($urandom % 4) != 3;
                aim_addr <= pat[$urandom % 3];
                aim_data <= ($urandom % 2) ? dat : dat ^ (16'h1 << ($urandom % 16));
            end
        end
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
